// >>> test/tgc_gate_control_bench.sv
// self-checking bench for the timer gate control block
`timescale 1ns/10ps
module tgc_gate_control_bench;
   logic clk = 0, rst = 1, run = 0, gateSourceSelect = 0, gatePolarity = 1, gateEnable = 0, gateToggleEnable = 0;
   logic gateSinglePulseEnable = 0, armSet = 0, armClear = 0, countTick = 0, flagClear = 0, gateEventIrqEnable = 0;
   logic [7:0] auxTimerValue = 8'h10;
   logic gateInputPin, gatePulseArm, gateLevelValue, gateEventFlag, irqRequest, countEnable;
   logic [15:0] count;
   int nMismatch = 0, numChecks = 0;
   always #2.5 clk = ~clk;
   tgc_gate_source_model #(.HALF(8)) tgc_gate_source_model_i (.clk, .run, .gateInputPin);
   tgc_gate_control tgc_gate_control_i (.clk, .rst, .gateInputPin, .auxTimerValue, .gateSourceSelect, .gatePolarity,
      .gateEnable, .gateToggleEnable, .gateSinglePulseEnable, .armSet, .armClear, .countTick, .flagClear,
      .gateEventIrqEnable, .gatePulseArm, .gateLevelValue, .gateEventFlag, .irqRequest, .countEnable, .count);
   // verdict and end of run
   task completeRun();
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : completeRun
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task chk(input logic got, input logic exp);
      numChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("wrong value at %0t: got %b want %b", $time, got, exp);
      end
   endtask : chk
   // bounded wait on the level output or the pin
   task wt(input bit lvl, input logic v);
      int i;
      for (i = 0; i < 40 && (lvl ? gateLevelValue : gateInputPin) !== v; i++) step(1);
      if (i == 40) begin
         nMismatch++;
         $display("wrong value at %0t: wait ran out", $time);
         completeRun();
      end
   endtask : wt
   // main sequence
   initial begin
      step(5);
      rst = 0;
      chk(gateEventFlag, 1'b0);
      gateEventIrqEnable = 1;
      run = 1;
      wt(1, 1'b1);
      wt(1, 1'b0);
      chk(gateEventFlag, 1'b1);
      chk(irqRequest, 1'b1);
      run = 0;
      step(3);
      chk(gateEventFlag, 1'b1);
      flagClear = 1;
      step(1);
      flagClear = 0;
      chk(gateEventFlag, 1'b0);
      gateSourceSelect = 1;
      auxTimerValue = 8'hFF;
      step(1);
      auxTimerValue = 8'h00;
      wt(1, 1'b1);
      wt(1, 1'b0);
      chk(gateEventFlag, 1'b1);
      gateSourceSelect = 0;
      countTick = 1;
      step(3);
      chk(count === 16'h0003, 1'b1);
      countTick = 0;
      gateEnable = 1;
      step(2);
      countTick = 1;
      step(3);
      chk(count === 16'h0003, 1'b1);
      chk(countEnable, 1'b0);
      countTick = 0;
      gateEnable = 0;
      gateToggleEnable = 1;
      run = 1;
      wt(0, 1'b1);
      step(2);
      chk(gateLevelValue, 1'b1);
      wt(0, 1'b0);
      step(2);
      chk(gateLevelValue, 1'b1);
      gateToggleEnable = 0;
      step(2);
      gateToggleEnable = 1;
      step(2);
      chk(gateLevelValue, 1'b0);
      run = 0;
      gateToggleEnable = 0;
      armSet = 1;
      step(1);
      armSet = 0;
      chk(gatePulseArm, 1'b0);
      gateSinglePulseEnable = 1;
      step(1);
      armSet = 1;
      step(1);
      armSet = 0;
      chk(gatePulseArm, 1'b1);
      run = 1;
      wt(1, 1'b1);
      wt(1, 1'b0);
      chk(gatePulseArm, 1'b0);
      wt(0, 1'b1);
      step(2);
      chk(gateLevelValue, 1'b0);
      gateToggleEnable = 1;
      armSet = 1;
      step(1);
      armSet = 0;
      wt(1, 1'b1);
      wt(0, 1'b0);
      step(2);
      chk(gateLevelValue, 1'b1);
      wt(1, 1'b0);
      chk(gatePulseArm, 1'b0);
      // rearm, then leave single-pulse mode with a software clear of the arm bit
      run = 0;
      gateToggleEnable = 0;
      armSet = 1;
      step(1);
      armSet = 0;
      chk(gatePulseArm, 1'b1);
      gateSinglePulseEnable = 0;
      armClear = 1;
      step(1);
      armClear = 0;
      chk(gatePulseArm, 1'b0);
      // low polarity inverts the idle pin; toggle mode stays off meanwhile
      gatePolarity = 0;
      step(2);
      chk(gateLevelValue, 1'b1);
      // reset in mid-run clears the sticky state and the counter
      gatePolarity = 1;
      rst = 1;
      step(2);
      rst = 0;
      chk(gateEventFlag, 1'b0);
      chk(irqRequest, 1'b0);
      chk(gateLevelValue, 1'b0);
      chk(count === 16'h0000, 1'b1);
      step(2);
      chk(countEnable, 1'b1);
      completeRun();
   end
endmodule : tgc_gate_control_bench

// >>> test/tgc_gate_control_monitor.sv
// port checker for the timer gate control block
`timescale 1ns/10ps
module tgc_gate_control_monitor (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        gateInputPin,
   input  wire logic        gateSourceSelect,
   input  wire logic        gatePolarity,
   input  wire logic        gateToggleEnable,
   input  wire logic        gateSinglePulseEnable,
   input  wire logic        gateEnable,
   input  wire logic        armSet,
   input  wire logic        countTick,
   input  wire logic        flagClear,
   input  wire logic        gateEventIrqEnable,
   input  wire logic        gatePulseArm,
   input  wire logic        gateLevelValue,
   input  wire logic        gateEventFlag,
   input  wire logic        irqRequest,
   input  wire logic        countEnable,
   input  wire logic [15:0] count
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // armed capture whose window closes
   sequence armedFall;
      gatePulseArm && gateSinglePulseEnable && !armSet ##1 $fell(gateLevelValue);
   endsequence
   // plain mode level follows the pin one cycle later
   level_follow_a: assert property (!$past(rst) && !$past(gateToggleEnable) && !$past(gateSinglePulseEnable)
      && !$past(gateSourceSelect) && $past(gatePolarity) |-> gateLevelValue == $past(gateInputPin)) else $error("level");
   flag_fall_a: assert property ($fell(gateLevelValue) |-> gateEventFlag) else $error("flag");
   flag_hold_a: assert property (gateEventFlag && !flagClear |=> gateEventFlag) else $error("sticky");
   irq_follow_a: assert property (!$past(rst) |-> irqRequest == (gateEventFlag && $past(gateEventIrqEnable)))
      else $error("irq");
   free_count_a: assert property (!$past(rst) && !$past(gateEnable) |-> countEnable) else $error("free");
   count_step_a: assert property (!gateEnable && countEnable && countTick |=> count == $past(count) + 1'b1)
      else $error("count");
   arm_refuse_a: assert property (armSet && !gateSinglePulseEnable && !gatePulseArm |=> !gatePulseArm)
      else $error("arm");
   arm_done_a: assert property (armedFall |-> !gatePulseArm) else $error("done");
   pulse_idle_a: assert property (gateSinglePulseEnable && !gatePulseArm && !armSet && !gateLevelValue
      |=> !gateLevelValue) else $error("idle");
endmodule : tgc_gate_control_monitor
bind tgc_gate_control tgc_gate_control_monitor mon_i (.clk, .rst, .gateInputPin, .gateSourceSelect, .gatePolarity,
   .gateToggleEnable, .gateSinglePulseEnable, .gateEnable, .armSet, .countTick, .flagClear, .gateEventIrqEnable,
   .gatePulseArm, .gateLevelValue, .gateEventFlag, .irqRequest, .countEnable, .count);

// >>> test/tgc_gate_source_model.sv
// far-side source that drives the external gate pin
`timescale 1ns/10ps
module tgc_gate_source_model #(
   parameter int HALF = 8
) (
   input  wire logic clk,
   input  wire logic run,
   output logic      gateInputPin
);
   int cnt = 0;
   initial gateInputPin = 1'b0;
   // square wave while running, pulled low when idle; changes land just after the edge
   always @(posedge clk) begin
      cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
      if (!run) gateInputPin <= #1 1'b0;
      else if (cnt == HALF - 1) gateInputPin <= #1 ~gateInputPin;
   end
endmodule : tgc_gate_source_model

// >>> verilog/tgc_aux_overflow.sv
// auxiliary timer rollover detector making a one-cycle gate pulse
`timescale 1ns/10ps
module tgc_aux_overflow #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] auxValue,
   output logic                  overflowPulse
);
   // the rollover compare uses the 8-bit package constants
   if (WIDTH != 8) begin : gBadWidth
      $error("tgc_aux_overflow: width must be 8");
   end

   logic [WIDTH-1:0] lastValue;
   logic             next_overflowPulse;

   // rollover from all ones to zero gives a high pulse
   always_comb begin
      next_overflowPulse = (lastValue == tgc_pkg::AUX_MAX) && (auxValue == tgc_pkg::AUX_ZERO);
   end

   // register last value and pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         lastValue     <= tgc_pkg::AUX_ZERO;
         overflowPulse <= 1'b0;
      end else begin
         lastValue     <= auxValue;
         overflowPulse <= next_overflowPulse;
      end
   end
endmodule : tgc_aux_overflow

// >>> verilog/tgc_gate_control.sv
// gate control for the 16-bit counting timer
`timescale 1ns/10ps
module tgc_gate_control #(
   parameter int CNT_WIDTH = 16
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 gateInputPin,
   input  wire logic [7:0]           auxTimerValue,
   input  wire logic                 gateSourceSelect,
   input  wire logic                 gatePolarity,
   input  wire logic                 gateEnable,
   input  wire logic                 gateToggleEnable,
   input  wire logic                 gateSinglePulseEnable,
   input  wire logic                 armSet,
   input  wire logic                 armClear,
   input  wire logic                 countTick,
   input  wire logic                 flagClear,
   input  wire logic                 gateEventIrqEnable,
   output logic                      gatePulseArm,
   output logic                      gateLevelValue,
   output logic                      gateEventFlag,
   output logic                      irqRequest,
   output logic                      countEnable,
   output logic [CNT_WIDTH-1:0]      count
);
   // ==========================================================
   // parameter check
   // the reset constant and the port checker hold a counter of at most 16 bits
   if (CNT_WIDTH < 1 || CNT_WIDTH > 16) begin : gBadWidth
      $error("tgc_gate_control: counter width must lie between 1 and 16");
   end

   // ==========================================================
   // gate source
   logic auxPulse;
   logic rawGate;
   logic srcPrev;
   logic srcRise;
   logic toggleFf;
   logic next_toggleFf;
   logic next_srcPrev;

   // auxiliary rollover detector; its pulse is one cycle wide and one cycle late
   tgc_aux_overflow #(
      .WIDTH         (8)
   ) tgc_aux_overflow_i (
      .clk           (clk),
      .rst           (rst),
      .auxValue      (auxTimerValue),
      .overflowPulse (auxPulse)
   );

   // pick source and apply polarity
   // a low polarity inverts the source before any edge is taken, so the toggle and
   // the sequencer always work on active-high edges
   always_comb begin
      rawGate = (gateSourceSelect == tgc_pkg::SRC_AUX_OVF) ? auxPulse : gateInputPin;
      rawGate = rawGate ^ ~gatePolarity; // polarity high passes the source unchanged
      srcRise = rawGate & ~srcPrev;
   end

   // ==========================================================
   // toggle flip-flop
   // a clear enable wins over a rising edge, so the flip-flop starts from zero
   // on the first edge after toggle mode is turned on
   always_comb begin
      next_srcPrev  = rawGate;
      next_toggleFf = toggleFf;
      if (!gateToggleEnable) begin
         next_toggleFf = 1'b0;
      end else if (srcRise) begin
         next_toggleFf = ~toggleFf;
      end
   end

   // register toggle state and source history
   always_ff @(posedge clk) begin
      if (rst) begin
         toggleFf <= tgc_pkg::RST_TOGGLE;
         srcPrev  <= 1'b0;
      end else begin
         toggleFf <= next_toggleFf;
         srcPrev  <= next_srcPrev;
      end
   end

   // ==========================================================
   // single-pulse sequencer and gate level
   tgc_pkg::tgc_pulse_state_t state;
   tgc_pkg::tgc_pulse_state_t next_state;
   logic shapedGate;
   logic shapedPrev;
   logic shapedRise;
   logic shapedFall;
   logic levelNow;
   logic next_gatePulseArm;
   logic next_gateLevelValue;

   // shaped gate is the toggled or direct source
   // the next toggle value keeps the toggled gate in step with the direct one
   always_comb begin
      shapedGate = gateToggleEnable ? next_toggleFf : rawGate;
      shapedRise = shapedGate & ~shapedPrev;
      shapedFall = ~shapedGate & shapedPrev;
   end

   // arm and window sequencing
   // idle waits for the arm bit, wait_lead for the opening edge, counting for the
   // closing edge; a software clear is honoured in every state and in either mode
   always_comb begin
      next_state        = state;
      next_gatePulseArm = gatePulseArm;
      if (!gateSinglePulseEnable) begin
         next_state = tgc_pkg::TGC_IDLE;
         if (armClear) next_gatePulseArm = 1'b0;
      end else begin
         unique case (state)
            tgc_pkg::TGC_IDLE: begin
               if (gatePulseArm) next_state = tgc_pkg::TGC_WAIT_LEAD;
            end
            tgc_pkg::TGC_WAIT_LEAD: begin
               if (!gatePulseArm) next_state = tgc_pkg::TGC_IDLE;
               else if (shapedRise) next_state = tgc_pkg::TGC_COUNTING;
            end
            tgc_pkg::TGC_COUNTING: begin
               // the closing edge ends the window and disarms
               if (shapedFall) begin
                  next_state        = tgc_pkg::TGC_IDLE;
                  next_gatePulseArm = 1'b0;
               end
            end
         endcase
         if (armClear) begin
            next_gatePulseArm = 1'b0;
            next_state        = tgc_pkg::TGC_IDLE;
         end
      end
      // a software set outranks a hardware clear in the same cycle
      if (armSet && gateSinglePulseEnable) next_gatePulseArm = 1'b1;
   end

   // gate level as seen by the counter
   // the opening edge counts in its own cycle; outside a window the level stays low
   always_comb begin
      if (gateSinglePulseEnable) begin
         levelNow = (state == tgc_pkg::TGC_COUNTING) && shapedGate;
         if (state == tgc_pkg::TGC_WAIT_LEAD && shapedRise) levelNow = 1'b1;
      end else begin
         levelNow = shapedGate;
      end
      next_gateLevelValue = levelNow;
   end

   // register sequencer, arm bit, edge history and gate level
   always_ff @(posedge clk) begin
      if (rst) begin
         state          <= tgc_pkg::TGC_IDLE;
         gatePulseArm   <= tgc_pkg::RST_ARM;
         shapedPrev     <= 1'b0;
         gateLevelValue <= tgc_pkg::RST_LEVEL;
      end else begin
         state          <= next_state;
         gatePulseArm   <= next_gatePulseArm;
         shapedPrev     <= shapedGate;
         gateLevelValue <= next_gateLevelValue;
      end
   end

   // ==========================================================
   // event flag, interrupt and counter
   logic                 next_gateEventFlag;
   logic                 next_irqRequest;
   logic                 next_countEnable;
   logic [CNT_WIDTH-1:0] next_count;

   // set wins over clear; edge taken regardless of gate enable
   // flag and request are built from the next level, so they rise together with
   // the falling level; the counter uses the registered enable, one cycle later
   always_comb begin
      next_gateEventFlag = gateEventFlag;
      if (flagClear) next_gateEventFlag = 1'b0;
      if (gateLevelValue && !next_gateLevelValue) next_gateEventFlag = 1'b1;
      next_irqRequest  = next_gateEventFlag & gateEventIrqEnable;
      next_countEnable = gateEnable ? next_gateLevelValue : 1'b1;
      next_count       = count;
      if (countTick && countEnable) next_count = CNT_WIDTH'(count + 1'b1); // wraps at the top
   end

   // register flag, request, enable and counter
   always_ff @(posedge clk) begin
      if (rst) begin
         gateEventFlag <= tgc_pkg::RST_FLAG;
         irqRequest    <= 1'b0;
         countEnable   <= 1'b0;
         count         <= tgc_pkg::RST_COUNT[CNT_WIDTH-1:0];
      end else begin
         gateEventFlag <= next_gateEventFlag;
         irqRequest    <= next_irqRequest;
         countEnable   <= next_countEnable;
         count         <= next_count;
      end
   end
endmodule : tgc_gate_control

// >>> verilog/tgc_pkg.sv
// package of constants and types for the timer gate control block
package tgc_pkg;
   // gate source selection codes
   localparam logic       SRC_PIN      = 1'b0;
   localparam logic       SRC_AUX_OVF  = 1'b1;
   // auxiliary timer rollover values
   localparam logic [7:0] AUX_MAX      = 8'hFF;
   localparam logic [7:0] AUX_ZERO     = 8'h00;
   // reset values of the control state
   localparam logic       RST_TOGGLE   = 1'b0;
   localparam logic       RST_ARM      = 1'b0;
   localparam logic       RST_FLAG     = 1'b0;
   localparam logic       RST_LEVEL    = 1'b0;
   localparam logic [15:0] RST_COUNT   = 16'h0000;
   // single-pulse sequencer states
   typedef enum logic [1:0] {
      TGC_IDLE,
      TGC_WAIT_LEAD,
      TGC_COUNTING
   } tgc_pulse_state_t;
endpackage : tgc_pkg
